// [rtl/uisl_pkg.sv]
// constants shared by the usb interrupt status logic
package uisl_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [15:0] STATUS_FLAG_IDX = 16'h0f62;
  localparam logic [15:0] ERROR_FLAG_IDX = 16'h0f63;
  localparam logic [15:0] ERROR_ENABLE_IDX = 16'h0f37;
  localparam logic [15:0] STATUS_ENABLE_IDX = 16'h0f36;
  localparam logic [15:0] CONTROL_IDX = 16'h0f64;
  localparam logic [15:0] DEV_ADDR_IDX = 16'h0f65;
  localparam logic [15:0] XFER_STATUS_IDX = 16'h0f66;
  // ==========================================================
  // status flag bit positions, plus the suspend bit of the control register
  localparam int FRAME_START_BIT = 6;
  localparam int STALL_SENT_BIT = 5;
  localparam int BUS_IDLE_BIT = 4;
  localparam int TRANSACTION_DONE_BIT = 3;
  localparam int BUS_ACTIVITY_BIT = 2;
  localparam int ERROR_SUMMARY_BIT = 1;
  localparam int BUS_RESET_BIT = 0;
  localparam int SUSPEND_BIT = 1;
  // ==========================================================
  // masks and reset values
  localparam logic [7:0] STATUS_WR_MASK = 8'h7d;
  localparam logic [7:0] ERROR_IMPL_MASK = 8'h9f;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ERROR_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [6:0] DEV_ADDR_RESET = 7'h00;
  localparam logic [6:0] DEV_ADDR_ON_BUS_RESET = 7'h00;
  // ==========================================================
  // transfer status fifo
  localparam int XFER_FIFO_DEPTH = 4;
  localparam logic [2:0] XFER_FIFO_FULL = 3'h4;
  // ==========================================================
  // line state and idle timing
  localparam logic [1:0] LINE_J_STATE = 2'h2;
  localparam int CLK_MHZ = 125;
  localparam int IDLE_TIME_US = 3000;
  localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;
  localparam int IDLE_CNT_W = 20;
endpackage

// [rtl/uisl_det_if.sv]
// link between the register logic and the line monitor
`timescale 1ns/100ps
`default_nettype none
interface uisl_det_if;
  logic suspend;
  logic idle_evt;
  logic actv_evt;
  modport regs (output suspend, input idle_evt, input actv_evt);
  modport det (input suspend, output idle_evt, output actv_evt);
endinterface
`default_nettype wire

// [rtl/uisl_line_monitor.sv]
// bus idle and bus activity detection on the d+/d- lines
`timescale 1ns/100ps
`default_nettype none
module uisl_line_monitor #(
  parameter int P_IDLE_CYCLES = uisl_pkg::IDLE_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // bus lines
  input wire logic i_dp,
  input wire logic i_dm,
  // towards register logic
  uisl_det_if.det det
);
  localparam int CW = uisl_pkg::IDLE_CNT_W;
  localparam logic [CW-1:0] IDLE_LAST = CW'(P_IDLE_CYCLES - 1);

  logic [1:0] sync1, sync2, prev;
  logic [1:0] next_sync1, next_sync2, next_prev;
  logic [uisl_pkg::IDLE_CNT_W-1:0] cnt, next_cnt;
  logic arm, next_arm;
  logic idle_evt, next_idle_evt;
  logic actv_evt, next_actv_evt;

  // ==========================================================
  // next state
  always_comb begin
    next_sync1 = {i_dp, i_dm};
    next_sync2 = sync1;
    next_prev = sync2;
    next_cnt = cnt;
    next_idle_evt = 1'b0;
    next_actv_evt = 1'b0;
    next_arm = arm;
    // continuous j state for the idle time
    if (sync2 != uisl_pkg::LINE_J_STATE) begin
      next_cnt = '0;
    end else if (cnt != IDLE_LAST) begin
      next_cnt = cnt + 1'b1;
      // one event per idle stretch, none while suspended
      next_idle_evt = (cnt == IDLE_LAST - 1'b1) && !det.suspend; // RQ8 RQ5
    end
    // activity counts only once per idle episode
    if (arm && sync2 != prev) begin
      next_actv_evt = 1'b1; // RQ11
      next_arm = 1'b0; // RQ18
    end else if (idle_evt) begin
      next_arm = 1'b1; // RQ18
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync1 <= uisl_pkg::LINE_J_STATE;
      sync2 <= uisl_pkg::LINE_J_STATE;
      prev <= uisl_pkg::LINE_J_STATE;
      cnt <= '0;
      arm <= 1'b0;
      idle_evt <= 1'b0;
      actv_evt <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev <= next_prev;
      cnt <= next_cnt;
      arm <= next_arm;
      idle_evt <= next_idle_evt;
      actv_evt <= next_actv_evt;
    end
  end

  assign det.idle_evt = idle_evt;
  assign det.actv_evt = actv_evt;
endmodule
`default_nettype wire

// [rtl/uisl_top.sv]
// usb status interrupt flags, enables, error summary and wishbone slave
// Operation
// RQ1 - two layers: status flags, error flags, enables
// RQ2 - enabled status flags ORed into one request
// RQ3 - flag stays set until written zero
// RQ4 - writing one sets writable status flags
// RQ5 - suspended: only bus activity may be flagged
// RQ6 - frame start token sets bit 6
// RQ7 - stall handshake sent sets bit 5
// RQ8 - three ms continuous idle sets bit 4
// RQ9 - transaction done sets bit 3, status readable
// RQ10 - clearing bit 3 advances fifo, token entries only
// RQ11 - line activity sets bit 2, even suspended
// RQ12 - error summary bit 1 read-only, enabled errors
// RQ13 - bus reset sets bit 0, clears address
// RQ14 - firmware unmasks activity only after idle
// RQ15 - firmware leaves suspend by writing zero
// RQ16 - flags reset to zero, bit 7 zero
// RQ17 - enables gate only the request, not flags
// RQ18 - activity rearmed only by new idle
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module uisl_top #(
  parameter int P_IDLE_CYCLES = uisl_pkg::IDLE_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [31:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // serial engine events
  input wire logic i_sof_evt,
  input wire logic i_stall_evt,
  input wire logic i_trn_evt,
  input wire logic [7:0] i_trn_status,
  input wire logic i_trn_is_token,
  input wire logic i_bus_reset_evt,
  input wire logic [7:0] i_err_evt,
  // bus lines
  input wire logic i_dp,
  input wire logic i_dm,
  // outputs
  output logic o_module_irq,
  output logic o_suspend,
  output logic [6:0] o_dev_addr,
  output logic o_xfer_fifo_full
);
  localparam int D = uisl_pkg::XFER_FIFO_DEPTH;

  uisl_det_if det_link ();

  logic [7:0] flags, next_flags;
  logic [7:0] enables, next_enables;
  logic [7:0] err_flags, next_err_flags;
  logic [7:0] err_enables, next_err_enables;
  logic suspend, next_suspend;
  logic [6:0] dev_addr, next_dev_addr;
  logic [7:0] fifo_mem [D];
  logic [7:0] next_fifo_mem [D];
  logic fifo_tok [D];
  logic next_fifo_tok [D];
  logic [1:0] rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr;
  logic [2:0] fifo_cnt, next_fifo_cnt;
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic irq, next_irq;
  logic fifo_full, next_fifo_full;

  logic hit, wr, addr_ok;
  logic [15:0] idx;
  logic [7:0] wd, evt, rd_byte;
  logic push, pop, st_wr;
  logic [7:0] flag_upd;

  uisl_line_monitor #(
    .P_IDLE_CYCLES(P_IDLE_CYCLES)
  ) u_line_monitor (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_dp(i_dp),
    .i_dm(i_dm),
    .det(det_link.det)
  );

  assign det_link.suspend = suspend;

  // ==========================================================
  // bus decode and event gathering
  always_comb begin
    idx = i_wb_adr[17:2];
    addr_ok = (i_wb_adr[31:18] == 14'h0000) && (i_wb_adr[1:0] == 2'h0);
    hit = i_wb_cyc && i_wb_stb;
    // write lands at the edge where the master sees ack
    wr = hit && i_wb_we && ack && i_wb_sel[0] && addr_ok;
    st_wr = wr && idx == uisl_pkg::STATUS_FLAG_IDX;
    wd = i_wb_dat[7:0];
    evt = 8'h00;
    // the serial engine is unclocked while suspended
    evt[uisl_pkg::FRAME_START_BIT] = i_sof_evt && !suspend; // RQ6 RQ5
    evt[uisl_pkg::STALL_SENT_BIT] = i_stall_evt && !suspend; // RQ7 RQ5
    evt[uisl_pkg::BUS_IDLE_BIT] = det_link.idle_evt; // RQ8
    evt[uisl_pkg::TRANSACTION_DONE_BIT] = i_trn_evt && !suspend; // RQ9 RQ5
    evt[uisl_pkg::BUS_ACTIVITY_BIT] = det_link.actv_evt; // RQ11
    evt[uisl_pkg::BUS_RESET_BIT] = i_bus_reset_evt && !suspend; // RQ13 RQ5
  end

  // ==========================================================
  // per-bit status update: written value or hold, events win
  for (genvar g = 0; g < 8; g++) begin : g_flag
    if (uisl_pkg::STATUS_WR_MASK[g]) begin : g_wr
      assign flag_upd[g] = (st_wr ? wd[g] : flags[g]) | evt[g]; // RQ3 RQ4
    end else begin : g_ro
      assign flag_upd[g] = flags[g] | evt[g]; // RQ3 RQ17
    end
  end

  // ==========================================================
  // control group: enables, suspend, device address
  always_comb begin
    next_enables = enables;
    next_err_enables = err_enables;
    next_suspend = suspend;
    next_dev_addr = dev_addr;
    if (wr && idx == uisl_pkg::STATUS_ENABLE_IDX) begin
      // summary enable kept too, bit 7 stays zero
      next_enables = wd & (uisl_pkg::STATUS_WR_MASK | 8'h02);
    end
    if (wr && idx == uisl_pkg::ERROR_ENABLE_IDX) begin
      next_err_enables = wd & uisl_pkg::ERROR_IMPL_MASK; // RQ1
    end
    if (wr && idx == uisl_pkg::CONTROL_IDX) begin
      next_suspend = wd[uisl_pkg::SUSPEND_BIT]; // RQ15
    end
    if (wr && idx == uisl_pkg::DEV_ADDR_IDX) begin
      next_dev_addr = wd[6:0];
    end
    if (evt[uisl_pkg::BUS_RESET_BIT]) begin
      next_dev_addr = uisl_pkg::DEV_ADDR_ON_BUS_RESET; // RQ13
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      enables <= uisl_pkg::ENABLE_RESET;
      err_enables <= uisl_pkg::ENABLE_RESET;
      suspend <= 1'b0;
      dev_addr <= uisl_pkg::DEV_ADDR_RESET;
    end else begin
      enables <= next_enables;
      err_enables <= next_err_enables;
      suspend <= next_suspend;
      dev_addr <= next_dev_addr;
    end
  end

  // ==========================================================
  // transfer status fifo: pop on clearing the done flag
  always_comb begin
    next_fifo_mem = fifo_mem;
    next_fifo_tok = fifo_tok;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    // only token entries advance, others stay at the head
    pop = st_wr && flags[uisl_pkg::TRANSACTION_DONE_BIT]
      && !wd[uisl_pkg::TRANSACTION_DONE_BIT]
      && fifo_cnt != 3'h0 && fifo_tok[rd_ptr]; // RQ10
    // a full fifo drops further entries
    push = evt[uisl_pkg::TRANSACTION_DONE_BIT] && fifo_cnt != uisl_pkg::XFER_FIFO_FULL;
    if (push) begin
      next_fifo_mem[wr_ptr] = i_trn_status; // RQ9
      next_fifo_tok[wr_ptr] = i_trn_is_token;
      next_wr_ptr = wr_ptr + 2'h1;
    end
    if (pop) begin
      next_rd_ptr = rd_ptr + 2'h1; // RQ10
    end
    next_fifo_cnt = fifo_cnt + {2'h0, push} - {2'h0, pop};
    next_fifo_full = next_fifo_cnt == uisl_pkg::XFER_FIFO_FULL;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int i = 0; i < D; i++) begin
        fifo_mem[i] <= 8'h00;
        fifo_tok[i] <= 1'b0;
      end
      rd_ptr <= 2'h0;
      wr_ptr <= 2'h0;
      fifo_cnt <= 3'h0;
      fifo_full <= 1'b0;
    end else begin
      fifo_mem <= next_fifo_mem;
      fifo_tok <= next_fifo_tok;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      fifo_cnt <= next_fifo_cnt;
      fifo_full <= next_fifo_full;
    end
  end

  // ==========================================================
  // error layer: write zero clears, events win over the clear
  always_comb begin
    next_err_flags = err_flags;
    if (wr && idx == uisl_pkg::ERROR_FLAG_IDX) begin
      next_err_flags = err_flags & wd;
    end
    // the engine reports no errors while unclocked
    next_err_flags = (next_err_flags | (i_err_evt & {8{!suspend}}))
      & uisl_pkg::ERROR_IMPL_MASK; // RQ1 RQ5
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      err_flags <= uisl_pkg::ERROR_RESET;
    end else begin
      err_flags <= next_err_flags;
    end
  end

  // ==========================================================
  // status layer: done and summary on top of the per-bit update
  always_comb begin
    next_flags = flag_upd;
    // further pending entries raise the done flag again
    if (pop && next_fifo_cnt != 3'h0) begin
      next_flags[uisl_pkg::TRANSACTION_DONE_BIT] = 1'b1; // RQ9
    end
    // summary is read-only and built from enabled errors only
    next_flags[uisl_pkg::ERROR_SUMMARY_BIT] = |(next_err_flags & next_err_enables); // RQ12 RQ1
    next_flags[7] = 1'b0; // RQ16
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flags <= uisl_pkg::STATUS_RESET; // RQ16
    end else begin
      flags <= next_flags;
    end
  end

  // ==========================================================
  // module request: enables gate only the propagation
  always_comb begin
    next_irq = |(next_flags & next_enables); // RQ2 RQ17
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ==========================================================
  // read mux and acknowledge
  always_comb begin
    rd_byte = 8'h00;
    if (addr_ok) begin
      case (idx)
        uisl_pkg::STATUS_FLAG_IDX: rd_byte = flags;
        uisl_pkg::STATUS_ENABLE_IDX: rd_byte = enables;
        uisl_pkg::ERROR_FLAG_IDX: rd_byte = err_flags;
        uisl_pkg::ERROR_ENABLE_IDX: rd_byte = err_enables;
        uisl_pkg::CONTROL_IDX: rd_byte = {6'h00, suspend, 1'b0};
        uisl_pkg::DEV_ADDR_IDX: rd_byte = {1'b0, dev_addr};
        uisl_pkg::XFER_STATUS_IDX: rd_byte = fifo_mem[rd_ptr]; // RQ9
        default: rd_byte = 8'h00;
      endcase
    end
    next_ack = hit && !ack;
    next_rdata = (hit && !ack) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
  end

  // ==========================================================
  // bus group registers
  always_ff @(posedge i_ref_clk) begin
    // ack and read data stand for exactly one cycle
    if (i_rst) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign o_wb_ack = ack;
  assign o_wb_dat = rdata;
  assign o_module_irq = irq;
  assign o_suspend = suspend;
  assign o_dev_addr = dev_addr;
  assign o_xfer_fifo_full = fifo_full;
endmodule
`default_nettype wire

// [bench/uisl_top_assertions.sv]
// port checker for the usb interrupt status logic
`timescale 1ns/100ps
`default_nettype none
module uisl_top_chk (
  // watched ports
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [31:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_bus_reset_evt,
  input wire logic o_module_irq,
  input wire logic o_suspend,
  input wire logic [6:0] o_dev_addr,
  input wire logic o_xfer_fifo_full
);
  logic wr_ok;
  assign wr_ok = o_wb_ack && i_wb_we && i_wb_sel[0];
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ==========================================
  // bus and register behaviour
  a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_bit7_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 32'h0000_3d88
    |-> o_wb_dat[31:7] == 0) else $error("status upper bits not zero");
  a_rst_out: assert property ($fell(i_rst) |-> !o_module_irq && !o_suspend && o_dev_addr == 0)
    else $error("outputs not cleared by reset");
  a_susp_write: assert property (wr_ok && i_wb_adr == 32'h0000_3d90
    |=> o_suspend == $past(i_wb_dat[1])) else $error("suspend bit not written");
  a_addr_clear: assert property (i_bus_reset_evt && !o_suspend && !o_wb_ack
    |=> o_dev_addr == 7'h00) else $error("address not cleared by bus reset");
  a_addr_hold: assert property (!i_bus_reset_evt && !(wr_ok && i_wb_adr == 32'h0000_3d94)
    |=> $stable(o_dev_addr)) else $error("address changed without cause");
  a_fifo_hold: assert property (o_xfer_fifo_full && !o_wb_ack |=> o_xfer_fifo_full)
    else $error("fifo advanced without firmware clear");
endmodule
bind uisl_top uisl_top_chk i_uisl_top_chk (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_bus_reset_evt,
  .o_module_irq, .o_suspend, .o_dev_addr, .o_xfer_fifo_full);
`default_nettype wire

// [bench/uisl_host_model.sv]
// host side line model for the d+/d- pair
`timescale 1ns/100ps
`default_nettype none
module uisl_host_model (
  // control
  input wire logic i_ref_clk,
  input wire logic i_active,
  // lines
  output logic o_dp,
  output logic o_dm
);
  logic k_phase = 1'b0;
  // traffic alternates k and j, quiet rests at the pulled-up j level
  always @(posedge i_ref_clk) k_phase <= i_active ? ~k_phase : 1'b0;
  assign o_dp = ~k_phase;
  assign o_dm = k_phase;
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the usb interrupt status logic
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  // ==========================================
  // stimulus and design
  localparam logic [31:0] ST = 32'h0000_3d88, EF = 32'h0000_3d8c, EE = 32'h0000_3cdc;
  localparam logic [31:0] SE = 32'h0000_3cd8, CT = 32'h0000_3d90, DA = 32'h0000_3d94;
  localparam logic [31:0] XS = 32'h0000_3d98, UM = 32'h0000_0ff0;
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0, tok = 1'b1, act = 1'b1;
  logic [31:0] adr = '0, wdat = '0, rdat;
  logic [3:0] ev = '0;
  logic [7:0] err = '0, tstat = '0, q;
  logic ack, irq, susp, full, dp, dm;
  logic [6:0] dev_addr;
  int mismatches = 0, check_count = 0;
  always #4 clk = ~clk;
  uisl_top #(.P_IDLE_CYCLES(20)) i_uisl_top (.i_ref_clk(clk), .i_rst(rst), .i_wb_cyc(req),
    .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_sof_evt(ev[3]), .i_stall_evt(ev[2]),
    .i_trn_evt(ev[1]), .i_trn_status(tstat), .i_trn_is_token(tok), .i_bus_reset_evt(ev[0]),
    .i_err_evt(err), .i_dp(dp), .i_dm(dm), .o_module_irq(irq), .o_suspend(susp),
    .o_dev_addr(dev_addr), .o_xfer_fifo_full(full));
  uisl_host_model i_uisl_host_model (.i_ref_clk(clk), .i_active(act), .o_dp(dp), .o_dm(dm));
  // ==========================================
  // bus cycle, event pulse and verdict
  task automatic wb(input logic [31:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    req <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e, input string s);
    wb(a, 1'b0, 8'h00);
    `CHK(s, e, q)
  endtask
  task automatic pulse(input logic [3:0] m, input logic [7:0] e);
    @(posedge clk);
    ev <= m;
    err <= e;
    @(posedge clk);
    ev <= 4'h0;
    err <= 8'h00;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_flags();
    int b[4] = '{6, 5, 3, 0};
    rd(ST, 8'h00, "reset status");
    wb(UM, 1'b1, 8'hff);
    rd(UM, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << (3 - i), 8'h00);
      rd(ST, 8'h01 << b[i], "flag set");
      `CHK("irq masked", 1'b0, irq)
      wb(SE, 1'b1, 8'h01 << b[i]);
      wb(ST, 1'b1, 8'h01 << b[i]);
      `CHK("irq on", 1'b1, irq)
      rd(ST, 8'h01 << b[i], "one kept");
      wb(ST, 1'b1, 8'h00);
      wb(SE, 1'b1, 8'h00);
      rd(ST, 8'h00, "zero clears");
      `CHK("irq off", 1'b0, irq)
    end
    wb(ST, 1'b1, 8'hff);
    rd(ST, 8'h7d, "forced");
    wb(ST, 1'b1, 8'h00);
  endtask
  task automatic t_errors();
    pulse(4'h0, 8'h01);
    rd(ST, 8'h00, "summary masked");
    rd(EF, 8'h01, "error flag");
    wb(EE, 1'b1, 8'h01);
    rd(ST, 8'h02, "summary");
    wb(ST, 1'b1, 8'h00);
    rd(ST, 8'h02, "summary kept");
    wb(EF, 1'b1, 8'h00);
    rd(ST, 8'h00, "summary gone");
    wb(EE, 1'b1, 8'h00);
  endtask
  task automatic t_fifo();
    for (int i = 1; i <= 5; i++) begin
      tstat <= 8'(i);
      pulse(4'h2, 8'h00);
    end
    rd(XS, 8'h01, "head");
    `CHK("fifo full", 1'b1, full)
    wb(ST, 1'b1, 8'h00);
    rd(XS, 8'h02, "advanced");
    rd(ST, 8'h08, "next entry");
    repeat (3) wb(ST, 1'b1, 8'h00);
    rd(ST, 8'h00, "drained");
    tok <= 1'b0;
    tstat <= 8'h77;
    pulse(4'h2, 8'h00);
    wb(ST, 1'b1, 8'h00);
    rd(XS, 8'h77, "no advance");
    tok <= 1'b1;
  endtask
  task automatic t_bus_reset();
    wb(DA, 1'b1, 8'h55);
    rd(DA, 8'h55, "address");
    pulse(4'h1, 8'h00);
    rd(ST, 8'h01, "reset flag");
    `CHK("address cleared", 7'h00, dev_addr)
    wb(ST, 1'b1, 8'h00);
  endtask
  task automatic t_suspend();
    act <= 1'b0;
    repeat (10) @(posedge clk);
    rd(ST, 8'h00, "early idle");
    repeat (30) @(posedge clk);
    rd(ST, 8'h10, "idle");
    wb(SE, 1'b1, 8'h04);
    wb(CT, 1'b1, 8'h02);
    pulse(4'h8, 8'h00);
    rd(ST, 8'h10, "sof ignored");
    `CHK("suspend", 1'b1, susp)
    act <= 1'b1;
    repeat (10) @(posedge clk);
    rd(ST, 8'h14, "activity");
    `CHK("activity irq", 1'b1, irq)
    wb(CT, 1'b1, 8'h00);
    repeat (10) @(posedge clk);
    wb(ST, 1'b1, 8'h00);
    repeat (10) @(posedge clk);
    rd(ST, 8'h00, "no rearm");
    wb(SE, 1'b1, 8'h00);
  endtask
  // ==========================================
  // sequence and watchdog
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_flags();
    t_errors();
    t_fifo();
    t_bus_reset();
    t_suspend();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
